// ### core/timer_pkg.sv
// package for the gated sixteen-bit timer: register map, fields, resets.
// assumes a 32-bit classic wishbone slave with byte-wide registers in the low lane.
package timer_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_TIMER_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_GATE_CONTROL = 5'h04;
  localparam logic [4:0] ADDR_COUNT_LOW = 5'h08;
  localparam logic [4:0] ADDR_COUNT_HIGH = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  // ----------------------------------------------------------------
  // timer_control fields
  // ----------------------------------------------------------------
  localparam int TC_CLOCK_SELECT_LSB = 6;
  localparam int TC_PRESCALE_LSB = 4;
  localparam int TC_OSC_ENABLE = 3;
  localparam int TC_NO_SYNC = 2;
  localparam int TC_RUN_ENABLE = 0;
  localparam logic [7:0] TC_WRITE_MASK = 8'hfd;
  // ----------------------------------------------------------------
  // gate_control fields, status flag bit and control reset value
  // ----------------------------------------------------------------
  localparam int GC_GATE_ENABLE = 7;
  localparam int GC_POLARITY = 6;
  localparam int GC_TOGGLE = 5;
  localparam int GC_SOURCE_LSB = 0;
  localparam logic [7:0] GC_WRITE_MASK = 8'he3;
  localparam int ST_OVERFLOW = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CS_INSTR = 2'h0, CS_SYSTEM = 2'h1, CS_EXTERNAL = 2'h2, CS_CAPOSC = 2'h3
  } clock_select_e;
  typedef enum logic [1:0] {
    GS_PIN = 2'h0, GS_EIGHT_BIT = 2'h1, GS_PERIOD = 2'h2, GS_WATCHDOG = 2'h3
  } gate_source_e;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage : timer_pkg

// ### core/pin_sync_if.sv
// carries synchronised pin levels and their one-cycle edge pulses.
// assumes one producer (pin_sync) and one consumer on the same clock.
interface pin_sync_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;
  modport producer (output level, rise, fall);
  modport consumer (input level, rise, fall);
endinterface : pin_sync_if

// ### core/pin_sync.sv
// three-stage synchroniser for asynchronous pins with edge pulses.
// assumes pins may change at any time relative to clk_in.
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,                // system clock
  input wire logic sys_rst_in,            // synchronous reset, active high
  input wire logic [WIDTH-1:0] pins_in,   // raw pin levels
  pin_sync_if.producer sync_out           // filtered levels and edges
);
  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
  logic [WIDTH-1:0] nxt_lvl, nxt_rise, nxt_fall;

  // a change counts only once the second and third stages agree
  always_comb begin
    nxt_lvl = lvl_ff;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_lvl[i] = s3_ff[i];
      end
    end
    nxt_rise = nxt_lvl & ~lvl_ff;
    nxt_fall = ~nxt_lvl & lvl_ff;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
      rise_ff <= '0;
      fall_ff <= '0;
    end else begin
      s1_ff <= pins_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  assign sync_out.level = lvl_ff;
  assign sync_out.rise = rise_ff;
  assign sync_out.fall = fall_ff;
endmodule // pin_sync

// ### core/gated_timer.sv
// gated sixteen-bit timer/counter with a classic wishbone register port.
// assumes one 100 mhz clock; external clocks and the gate pin arrive as pins.
//
// Decided for this implementation: register access over Wishbone and the address map.
module gated_timer
  import timer_pkg::*;
(
  input wire logic clk_in,                 // 100 mhz system clock
  input wire logic sys_rst_in,             // synchronous reset, active high
  input wire logic wb_cyc_i,               // wishbone cycle
  input wire logic wb_stb_i,               // wishbone strobe
  input wire logic wb_we_i,                // wishbone write enable
  input wire logic [4:0] wb_adr_i,         // wishbone byte address
  input wire logic [3:0] wb_sel_i,         // wishbone byte selects
  input wire logic [31:0] wb_dat_i,        // wishbone write data
  output logic [31:0] wb_dat_o,            // wishbone read data
  output logic wb_ack_o,                   // wishbone acknowledge
  input wire logic external_clock_pin_in,  // external count clock pin
  input wire logic caposc_in,              // capacitive-sensing oscillator
  input wire logic crystal_in_pin_in,      // crystal oscillator input
  input wire logic gate_pin_in,            // gate pin
  input wire logic sleep_in,               // processor is in sleep
  input wire logic [7:0] eight_bit_timer_in,   // eight-bit timer value
  input wire logic [7:0] period_match_timer_in, // period-match timer value
  input wire logic [7:0] period_value_in,  // period-match timer period
  input wire logic watchdog_overflow_in,   // watchdog overflow level
  input wire logic watchdog_enable_setting_in, // watchdog enable setting
  output logic crystal_out_pin_out,        // crystal amplifier output
  output logic crystal_out_pin_oe_out,     // amplifier drive enable
  output logic watchdog_osc_enable_out,    // watchdog osc/prescaler/counter on
  output logic watchdog_reset_enable_out,  // watchdog may reset or wake
  output logic overflow_flag_out,          // overflow flag level
  output logic wake_out                    // one-cycle wake request
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_EXT = 0;
  localparam int PIN_CAP = 1;
  localparam int PIN_XTAL = 2;
  localparam int PIN_GATE = 3;

  pin_sync_if #(.WIDTH(4)) pins ();

  pin_sync #(.WIDTH(4)) u_pin_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .pins_in({gate_pin_in, crystal_in_pin_in, caposc_in, external_clock_pin_in}),
    .sync_out(pins.producer)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] tctl_ff, nxt_tctl, gctl_ff, nxt_gctl;
  logic [15:0] count_ff, nxt_count;
  logic [2:0] presc_ff, nxt_presc;
  logic [1:0] idiv_ff, nxt_idiv;
  logic armed_ff, nxt_armed;
  logic ovf_ff, nxt_ovf;
  logic tog_ff, nxt_tog;
  logic gate_ok_ff, nxt_gate_ok;
  logic gsrc_ff, nxt_gsrc;
  logic ext_rise_d_ff, nxt_ext_rise_d;
  logic [7:0] t0_prev_ff, t2_prev_ff;
  logic t2_match_ff, nxt_t2_match;
  logic t0_pulse_ff, t2_pulse_ff, nxt_t0_pulse, nxt_t2_pulse;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic wake_ff, nxt_wake;
  logic wdt_osc_ff, wdt_rst_ff;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] presc_last(input logic [1:0] field);
    presc_last = 3'((4'h1 << field) - 4'h1);
  endfunction

  function automatic logic wr_hit(input logic [4:0] adr);
    wr_hit = wb_cyc_i && wb_stb_i && !ack_ff && wb_we_i && wb_sel_i[0]
             && (wb_adr_i == adr);
  endfunction

  logic run_en, gate_en, no_sync, osc_en, tog_mode, pol;
  logic [1:0] csel, psel, gsel;
  logic is_ext, ext_src, ext_src_rise, ext_src_fall, ext_edge;
  logic wr_low, wr_high, count_wr, tick, inc, count_en, async_ext;

  assign run_en = tctl_ff[TC_RUN_ENABLE];
  assign no_sync = tctl_ff[TC_NO_SYNC];
  assign osc_en = tctl_ff[TC_OSC_ENABLE];
  assign csel = tctl_ff[TC_CLOCK_SELECT_LSB +: 2];
  assign psel = tctl_ff[TC_PRESCALE_LSB +: 2];
  assign gate_en = gctl_ff[GC_GATE_ENABLE];
  assign pol = gctl_ff[GC_POLARITY];
  assign tog_mode = gctl_ff[GC_TOGGLE];
  assign gsel = gctl_ff[GC_SOURCE_LSB +: 2];
  assign wr_low = wr_hit(ADDR_COUNT_LOW);
  assign wr_high = wr_hit(ADDR_COUNT_HIGH);
  assign count_wr = wr_low || wr_high;
  assign is_ext = csel[1];
  assign async_ext = is_ext && no_sync;

  // ----------------------------------------------------------------
  // count clock selection
  // ----------------------------------------------------------------
  always_comb begin
    ext_src = 1'b0;
    ext_src_rise = 1'b0;
    ext_src_fall = 1'b0;
    case (clock_select_e'(csel))
      CS_EXTERNAL: begin
        if (osc_en) begin
          ext_src = pins.level[PIN_XTAL];
          ext_src_rise = pins.rise[PIN_XTAL];
          ext_src_fall = pins.fall[PIN_XTAL];
        end else begin
          ext_src = pins.level[PIN_EXT];
          ext_src_rise = pins.rise[PIN_EXT];
          ext_src_fall = pins.fall[PIN_EXT];
        end
      end
      CS_CAPOSC: begin
        ext_src = pins.level[PIN_CAP];
        ext_src_rise = pins.rise[PIN_CAP];
        ext_src_fall = pins.fall[PIN_CAP];
      end
      default: begin
        ext_src = 1'b0;
      end
    endcase
  end

  // synchronised mode adds one stage; switching modes can drop or repeat an edge
  assign ext_edge = no_sync ? ext_src_rise : ext_rise_d_ff;

  always_comb begin
    tick = 1'b0;
    case (clock_select_e'(csel))
      CS_INSTR: tick = !sleep_in && (idiv_ff == INSTR_DIV_LAST);
      CS_SYSTEM: tick = !sleep_in;
      // internal clocks stop in sleep; only the unsynchronised path keeps going
      default: tick = ext_edge && armed_ff && (no_sync || !sleep_in);
    endcase
  end

  // ----------------------------------------------------------------
  // gate path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_t2_match = t2_match_ff;
    if (period_match_timer_in != t2_prev_ff) begin
      nxt_t2_match = (period_match_timer_in == period_value_in);
    end
    nxt_t0_pulse = (t0_prev_ff == BYTE_MAX) && (eight_bit_timer_in == BYTE_ZERO);
    nxt_t2_pulse = t2_match_ff && (t2_prev_ff != period_match_timer_in)
                   && (period_match_timer_in == BYTE_ZERO);
    case (gate_source_e'(gsel))
      GS_PIN: nxt_gsrc = pins.level[PIN_GATE];
      GS_EIGHT_BIT: nxt_gsrc = t0_pulse_ff;
      GS_PERIOD: nxt_gsrc = t2_pulse_ff;
      GS_WATCHDOG: nxt_gsrc = watchdog_overflow_in;
      default: nxt_gsrc = 1'b0;
    endcase
    nxt_tog = tog_ff;
    if (!tog_mode || !run_en) begin
      nxt_tog = 1'b0;
    end else if (nxt_gsrc && !gsrc_ff) begin
      nxt_tog = !tog_ff;
    end
    // registering the gate keeps a racing source off the count enable
    nxt_gate_ok = ((tog_mode ? nxt_tog : nxt_gsrc) == pol);
  end

  assign count_en = run_en && (!gate_en || gate_ok_ff);
  assign inc = count_en && tick && (presc_ff == presc_last(psel)) && !count_wr;

  // ----------------------------------------------------------------
  // counter, prescaler, arming, overflow
  // ----------------------------------------------------------------
  always_comb begin
    nxt_idiv = 2'(idiv_ff + 2'h1);
    nxt_ext_rise_d = ext_src_rise;
    nxt_count = count_ff;
    nxt_presc = presc_ff;
    nxt_armed = armed_ff;
    nxt_ovf = ovf_ff;
    nxt_wake = 1'b0;
    if (count_en && tick) begin
      nxt_presc = (presc_ff == presc_last(psel)) ? 3'h0 : 3'(presc_ff + 3'h1);
    end
    if (inc) begin
      nxt_count = 16'(count_ff + 16'h1);
    end
    if (wr_low) begin
      nxt_count[7:0] = wb_dat_i[7:0];
    end
    if (wr_high) begin
      nxt_count[15:8] = wb_dat_i[7:0];
    end
    if (count_wr) begin
      nxt_presc = 3'h0;
    end
    if (count_wr || !run_en) begin
      nxt_armed = 1'b0;
    end else if (ext_src_fall) begin
      nxt_armed = 1'b1;
    end
    if (wr_hit(ADDR_STATUS) && wb_dat_i[ST_OVERFLOW]) begin
      nxt_ovf = 1'b0;
    end
    // a rollover in the clearing cycle still sets the flag
    if (inc && (count_ff == COUNT_MAX)) begin
      nxt_ovf = 1'b1;
      nxt_wake = sleep_in && async_ext;
    end
  end

  // ----------------------------------------------------------------
  // register bus: one wait state, reads come from a register
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_tctl = tctl_ff;
    nxt_gctl = gctl_ff;
    nxt_rdat = 32'h0;
    if (wr_hit(ADDR_TIMER_CONTROL)) begin
      nxt_tctl = wb_dat_i[7:0] & TC_WRITE_MASK;
    end
    if (wr_hit(ADDR_GATE_CONTROL)) begin
      nxt_gctl = wb_dat_i[7:0] & GC_WRITE_MASK;
    end
    if (wb_cyc_i && wb_stb_i && !ack_ff && !wb_we_i) begin
      case (wb_adr_i)
        ADDR_TIMER_CONTROL: nxt_rdat[7:0] = tctl_ff;
        ADDR_GATE_CONTROL: nxt_rdat[7:0] = gctl_ff;
        ADDR_COUNT_LOW: nxt_rdat[7:0] = count_ff[7:0];
        ADDR_COUNT_HIGH: nxt_rdat[7:0] = count_ff[15:8];
        ADDR_STATUS: nxt_rdat[ST_OVERFLOW] = ovf_ff;
        default: nxt_rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tctl_ff <= CTRL_RESET;
      gctl_ff <= CTRL_RESET;
      count_ff <= '0;
      presc_ff <= '0;
      idiv_ff <= '0;
      armed_ff <= 1'b0;
      ovf_ff <= 1'b0;
      tog_ff <= 1'b0;
      gate_ok_ff <= 1'b0;
      gsrc_ff <= 1'b0;
      ext_rise_d_ff <= 1'b0;
      t0_prev_ff <= '0;
      t2_prev_ff <= '0;
      t2_match_ff <= 1'b0;
      t0_pulse_ff <= 1'b0;
      t2_pulse_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdat_ff <= '0;
      wake_ff <= 1'b0;
      wdt_osc_ff <= 1'b0;
      wdt_rst_ff <= 1'b0;
    end else begin
      tctl_ff <= nxt_tctl;
      gctl_ff <= nxt_gctl;
      count_ff <= nxt_count;
      presc_ff <= nxt_presc;
      idiv_ff <= nxt_idiv;
      armed_ff <= nxt_armed;
      ovf_ff <= nxt_ovf;
      tog_ff <= nxt_tog;
      gate_ok_ff <= nxt_gate_ok;
      gsrc_ff <= nxt_gsrc;
      ext_rise_d_ff <= nxt_ext_rise_d;
      t0_prev_ff <= eight_bit_timer_in;
      t2_prev_ff <= period_match_timer_in;
      t2_match_ff <= nxt_t2_match;
      t0_pulse_ff <= nxt_t0_pulse;
      t2_pulse_ff <= nxt_t2_pulse;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      wake_ff <= nxt_wake;
      wdt_osc_ff <= gate_en && (gsel == GS_WATCHDOG);
      wdt_rst_ff <= watchdog_enable_setting_in;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign overflow_flag_out = ovf_ff;
  assign wake_out = wake_ff;
  // oscillator drive stays on through sleep; it follows only its enable bit
  assign crystal_out_pin_out = osc_en;
  assign crystal_out_pin_oe_out = osc_en;
  assign watchdog_osc_enable_out = wdt_osc_ff;
  assign watchdog_reset_enable_out = wdt_rst_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_STOPPED: assert property (!run_en && !count_wr |=> $stable(count_ff))
    else $error("count moved while stopped");
  AST_WRITE_LOW: assert property (wr_low |=> count_ff[7:0] == $past(wb_dat_i[7:0]))
    else $error("low byte write lost");
  AST_PRESC_CLR: assert property (count_wr |=> presc_ff == 3'h0)
    else $error("prescaler not cleared by count write");
  AST_OVERFLOW: assert property (inc && count_ff == COUNT_MAX |=> ovf_ff && count_ff == 16'h0)
    else $error("rollover did not set flag");
  AST_TOGGLE_CLR: assert property (!tog_mode ##1 !tog_mode |-> !tog_ff)
    else $error("toggle flop not held clear");
  AST_ARM: assert property (count_wr |=> !armed_ff && (!inc || !is_ext))
    else $error("counted without falling edge");
  AST_GATE_HOLD: assert property (run_en && gate_en && !gate_ok_ff |-> !inc)
    else $error("counted while gate inactive");
  AST_WDT_OSC: assert property (gate_en && gsel == GS_WATCHDOG |=> watchdog_osc_enable_out)
    else $error("watchdog oscillator not enabled");
  AST_SLEEP: assert property (sleep_in && !async_ext |-> !inc)
    else $error("counted in sleep without async source");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !ack_ff |=> ack_ff ##1 !ack_ff)
    else $error("wishbone ack not one cycle");

  COV_ROLLOVER: cover property (inc && count_ff == COUNT_MAX);
  COV_GATED_COUNT: cover property (gate_en && inc);
  COV_ASYNC_SLEEP: cover property (sleep_in && async_ext && inc);
  COV_TOGGLE: cover property (tog_mode && $rose(tog_ff));
endmodule // gated_timer

// ### test/timer_far_side.sv
// far-side model: external clock pin, capacitive oscillator, crystal and gate pin.
// assumes pins move by non-blocking assignment right after a clk_in rising edge.
module timer_far_side #(
  parameter int XTAL_HALF = 6  // crystal half period in clk cycles, shortened to keep runs short
) (
  input wire logic clk_in,     // system clock
  input wire logic xtal_en_in, // amplifier enable from the timer
  output logic ext_clk_out,    // external count clock pin
  output logic caposc_out,     // capacitive oscillator
  output logic xtal_out,       // crystal input pin
  output logic gate_out        // gate pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int xcnt = 0;
  initial begin
    ext_clk_out = 1'b0;
    caposc_out = 1'b0;
    xtal_out = 1'b0;
    gate_out = 1'b0;
  end
  // the crystal swings only while its amplifier is enabled, sleep or not
  always @(posedge clk_in) begin
    xcnt <= (xtal_en_in && xcnt < XTAL_HALF - 1) ? xcnt + 1 : 0;
    if (!xtal_en_in) xtal_out <= 1'b0;
    else if (xcnt == XTAL_HALF - 1) xtal_out <= ~xtal_out;
  end
  task automatic put(input int sel, input logic lvl);
    @(posedge clk_in);
    case (sel)
      0: ext_clk_out <= lvl;
      1: caposc_out <= lvl;
      default: gate_out <= lvl;
    endcase
  endtask
  // n high pulses, each level held long enough to pass the pin synchronisers
  task automatic pulses(input int sel, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      put(sel, 1'b1);
      repeat (hold) @(posedge clk_in);
      put(sel, 1'b0);
      repeat (hold) @(posedge clk_in);
    end
  endtask
endmodule // timer_far_side

// ### test/gated_timer_bench.sv
// self-checking bench for gated_timer: wishbone tasks and one task per scenario.
// assumes timer_far_side drives the pins; the bench plays the outside timers.
module gated_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep = 1'b0, wd_ovf = 1'b0, wd_set = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic [7:0] t8 = 8'h00, tp = 8'h00, pv = 8'h05, rdv;
  logic wb_ack_o, xtal, xout, xtal_oe, wd_osc, wd_rst, ovf, wake, ext_clk, caposc, gate;
  logic wake_seen = 1'b0;
  logic [15:0] cnt;
  int n_errors = 0, n_compared = 0;
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) if (wake === 1'b1) wake_seen <= 1'b1;
  gated_timer dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .external_clock_pin_in(ext_clk), .caposc_in(caposc),
    .crystal_in_pin_in(xtal), .gate_pin_in(gate), .sleep_in(sleep),
    .eight_bit_timer_in(t8), .period_match_timer_in(tp), .period_value_in(pv),
    .watchdog_overflow_in(wd_ovf), .watchdog_enable_setting_in(wd_set),
    .crystal_out_pin_out(xout), .crystal_out_pin_oe_out(xtal_oe), .watchdog_osc_enable_out(wd_osc),
    .watchdog_reset_enable_out(wd_rst), .overflow_flag_out(ovf), .wake_out(wake));
  timer_far_side far (.clk_in(clk_in), .xtal_en_in(xtal_oe), .ext_clk_out(ext_clk),
    .caposc_out(caposc), .xtal_out(xtal), .gate_out(gate));
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic in_range(input string what, input logic [15:0] seen, input int lo, input int hi);
    check(what, {15'h0, seen >= lo && seen <= hi}, 16'h1);
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdv = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) check("ack", 16'h0, 16'h1);
  endtask
  task automatic get_count();
    wb(1'b0, ADDR_COUNT_LOW, 8'h00);
    cnt[7:0] = rdv;
    wb(1'b0, ADDR_COUNT_HIGH, 8'h00);
    cnt[15:8] = rdv;
  endtask
  // count writes happen with the timer stopped so no increment collides with them
  task automatic run_for(input logic [7:0] tc, input logic [15:0] pre, input int n);
    wb(1'b1, ADDR_TIMER_CONTROL, tc & 8'hfe);
    wb(1'b1, ADDR_COUNT_LOW, pre[7:0]);
    wb(1'b1, ADDR_COUNT_HIGH, pre[15:8]);
    wb(1'b1, ADDR_TIMER_CONTROL, tc);
    repeat (n) @(posedge clk_in);
    wb(1'b1, ADDR_TIMER_CONTROL, tc & 8'hfe);
    get_count();
  endtask
  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int a = 0; a <= 20; a += 4) begin
      wb(1'b0, 5'(a), 8'h00);
      check("reset value", {8'h0, rdv}, 16'h0);
    end
    wb(1'b1, ADDR_COUNT_LOW, 8'h34);
    wb(1'b1, ADDR_COUNT_HIGH, 8'h12);
    get_count();
    check("count bytes", cnt, 16'h1234);
    wb(1'b1, ADDR_GATE_CONTROL, 8'hff);
    wb(1'b0, ADDR_GATE_CONTROL, 8'h00);
    check("gate_control", {8'h0, rdv}, {8'h0, GC_WRITE_MASK});
    wd_set <= 1'b1;
    repeat (3) @(posedge clk_in);
    check("wdt osc on", {15'h0, wd_osc}, 16'h1);
    check("wdt reset", {15'h0, wd_rst}, 16'h1);
    wd_set <= 1'b0;
    wb(1'b1, ADDR_GATE_CONTROL, 8'h00);
    repeat (3) @(posedge clk_in);
    check("wdt osc off", {15'h0, wd_osc}, 16'h0);
    check("wdt reset off", {15'h0, wd_rst}, 16'h0);
  endtask
  task automatic t_rate();
    int d;
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        d = (s ? 1 : 4) << p;
        run_for({1'b0, s[0], p[1:0], 4'h1}, 16'h0, 256);
        in_range("rate", cnt, 256 / d - 1, 256 / d + 3);
      end
    end
    // internal clocks stop in sleep
    sleep <= 1'b1;
    run_for(8'h41, 16'h0, 40);
    sleep <= 1'b0;
    check("sleep stops", cnt, 16'h0);
    run_for(8'h41, 16'hfffd, 10);
    check("overflow flag", {15'h0, ovf}, 16'h1);
    wb(1'b0, ADDR_STATUS, 8'h00);
    check("status", {8'h0, rdv}, 16'h1);
    wb(1'b1, ADDR_STATUS, 8'h01);
    wb(1'b0, ADDR_STATUS, 8'h00);
    check("status cleared", {8'h0, rdv}, 16'h0);
  endtask
  task automatic wraps();
    for (int i = 0; i < 6; i++) begin
      repeat (20) @(posedge clk_in);
      t8 <= i[0] ? 8'h00 : 8'hff;
      tp <= i[0] ? 8'h00 : pv;
    end
  endtask
  task automatic t_gate();
    far.put(2, 1'b1);
    wb(1'b1, ADDR_GATE_CONTROL, 8'hc0);
    run_for(8'h40, 16'h0, 60);
    check("run off", cnt, 16'h0);
    run_for(8'h41, 16'h0, 60);
    in_range("gate active", cnt, 59, 64);
    wb(1'b1, ADDR_GATE_CONTROL, 8'h80);
    run_for(8'h41, 16'h0, 60);
    check("active low held", cnt, 16'h0);
    far.put(2, 1'b0);
    for (int g = 1; g < 3; g++) begin
      wb(1'b1, ADDR_GATE_CONTROL, 8'hc0 | 8'(g));
      fork
        run_for(8'h41, 16'h0, 150);
        wraps();
      join
      check("gate pulses", cnt, 16'h3);
    end
    // the watchdog gate is only meaningful in toggle mode
    wb(1'b1, ADDR_GATE_CONTROL, 8'he3);
    fork
      run_for(8'h41, 16'h0, 60);
      begin
        repeat (20) @(posedge clk_in);
        wd_ovf <= 1'b1;
        @(posedge clk_in);
        wd_ovf <= 1'b0;
      end
    join
    in_range("watchdog gate", cnt, 45, 58);
    wb(1'b1, ADDR_GATE_CONTROL, 8'he0);
    fork
      run_for(8'h41, 16'h0, 80);
      begin
        repeat (30) @(posedge clk_in);
        far.pulses(2, 1, 2);
      end
    join
    in_range("toggle", cnt, 40, 70);
    run_for(8'h41, 16'h0, 60);
    check("toggle cleared", cnt, 16'h0);
    wb(1'b1, ADDR_GATE_CONTROL, 8'h00);
  endtask
  task automatic t_ext(input logic [7:0] tc, input int sel, input logic [15:0] pre, input int slp);
    fork
      run_for(tc, pre, 140);
      begin
        repeat (20) @(posedge clk_in);
        sleep <= slp[0];
        far.pulses(sel, 4, 6);
        sleep <= 1'b0;
      end
    join
    check("edge count", cnt, pre + 16'h3);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_rate();
    t_gate();
    t_ext(8'h81, 0, 16'h0, 0);
    far.put(1, 1'b1);
    t_ext(8'hc1, 1, 16'h0, 0);
    t_ext(8'h85, 0, 16'hfffe, 1);
    check("wake", {15'h0, wake_seen}, 16'h1);
    wb(1'b1, ADDR_TIMER_CONTROL, 8'h88);
    repeat (50) @(posedge clk_in);
    check("amplifier on", {15'h0, xtal_oe}, 16'h1);
    check("amplifier drive", {15'h0, xout}, 16'h1);
    run_for(8'h89, 16'h0, 120);
    in_range("crystal", cnt, 7, 11);
    close_out();
  end
  initial begin
    repeat (30000) @(posedge clk_in);
    n_errors++;
    close_out();
  end
endmodule // gated_timer_bench
